// ===== core/aslc_params.svh
/*
  Constants for the serial register load control block: bit addresses,
  control register fields, reset values and divide counts.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef ASLC_PARAMS_SVH
`define ASLC_PARAMS_SVH

// ==========================================================
// Output bit addresses
`define ASLC_ADDR_RESET 5'h1F
`define ASLC_ADDR_BREAK 5'h11
`define ASLC_ADDR_RTS 5'h10
`define ASLC_ADDR_TEST 5'h0F
`define ASLC_ADDR_LDCTL 5'h0E
`define ASLC_ADDR_LDINT 5'h0D
`define ASLC_ADDR_LDRX 5'h0C
`define ASLC_ADDR_LDTX 5'h0B
`define ASLC_ADDR_DATA_TOP 5'h0A
`define ASLC_ADDR_BYTE_TOP 5'h07

// ==========================================================
// Control register fields
`define ASLC_CTL_STOP_HI 7
`define ASLC_CTL_STOP_LO 6
`define ASLC_CTL_PAR_ON 5
`define ASLC_CTL_PAR_ODD 4
`define ASLC_CTL_DIV4 3
`define ASLC_CTL_LEN_HI 1
`define ASLC_CTL_LEN_LO 0

// ==========================================================
// Reset values and divide figures
`define ASLC_CTL_RST 8'h00
`define ASLC_BYTE_RST 8'h00
`define ASLC_RATE_RST 11'h000
`define ASLC_FLAGS_RST 4'hF
`define ASLC_DIV_FAST 2'h3
`define ASLC_DIV_SLOW 2'h2
`define ASLC_LOOP_SPEEDUP 6'h20

`endif

// ===== core/aslc_pkg.sv
/*
  Types for the serial register load control block.
  Assumes aslc_params.svh is on the include path.
*/
package aslc_pkg;
  `include "aslc_params.svh"

  // Register picked by the load flags
  typedef enum logic [2:0] {
    ASLC_DST_CTL = 3'b000,
    ASLC_DST_INT = 3'b001,
    ASLC_DST_RATE = 3'b010,
    ASLC_DST_TXBUF = 3'b011,
    ASLC_DST_NONE = 3'b100
  } aslc_dst_t;

  // Transmitted stop bit count
  typedef enum logic [1:0] {
    ASLC_STOP_ONE = 2'b00,
    ASLC_STOP_ONE_HALF = 2'b01,
    ASLC_STOP_TWO = 2'b10
  } aslc_stop_t;
endpackage : aslc_pkg

// ===== core/aslc_wr_if.sv
/*
  Strobed single-bit write carrier between the top and the decoder.
  Assumes one clock domain; the top drives it from its ports.
*/
`timescale 1ns/100ps
interface aslc_wr_if;
  logic stb;
  logic [4:0] addr;
  logic data;
  modport src (output stb, output addr, output data);
  modport dst (input stb, input addr, input data);
endinterface : aslc_wr_if

// ===== core/aslc_clk_div.sv
/*
  Internal time base divider: one-cycle enable every 3 or 4 clocks.
  Assumes synchronous active-low reset copy from the top.
*/
`timescale 1ns/100ps
`include "aslc_params.svh"
module aslc_clk_div
  import aslc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_sync_b,
  // Control
  input wire logic div4_sel,
  // Enable out
  output logic tick
);
  logic [1:0] cnt_q;

  // ==========================================================
  // Divider
  // [RQ19] divide 3/4
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cnt_q <= 2'h0;
    end else if (cnt_q >= (div4_sel ? `ASLC_DIV_FAST : `ASLC_DIV_SLOW)) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // Pulse at wrap
  assign tick = (cnt_q == 2'h0);

  // [RQ19] period check
  property p_div_period;
    @(posedge clk) disable iff (!rst_sync_b)
      (tick && !div4_sel && $stable(div4_sel)) |-> ##1 !tick ##1 !tick ##1 (tick || div4_sel);
  endproperty
  a_div_period: assert property (p_div_period) else $error("divide by 3 period wrong"); // [RQ19]
endmodule : aslc_clk_div

// ===== core/aslc_core.sv
/*
  Write-side control of an asynchronous serial controller: command bits,
  prioritized load flags, control/interval/rate/buffer register loading.
  Assumes host bit writes synchronous to clk, one strobe per bit.
*/
//
// Overview of operation
// [RQ1] Writing one to request-send drives rts_b low at once.
// [RQ2] Writing zero keeps rts_b low until shift, buffer empty and break off.
// [RQ3] Loopback routes rts to cts, out to in, holds dsr low, timer x32.
// [RQ4] Clearing loopback restores pins and normal timer rate.
// [RQ5] Data bits 10..0 go to one register chosen by prioritized flags.
// [RQ6] Addresses 14..11 set or clear the four load flags.
// [RQ7] Any write to reset address sets all four load flags.
// [RQ8] With control select, bits 0..7 load the control register.
// [RQ9] Writing control bit 7 clears control select.
// [RQ10] Interval select loads interval register; its bit 7 clears the flag.
// [RQ11] Receive-rate select loads rx rate; its bit 10 clears the flag.
// [RQ12] Both rate selects load both rate registers together.
// [RQ13] Host clears transmit-rate select itself by writing bit 11.
// [RQ14] Control bits 7,6 select one and a half, two or one stop bits.
// [RQ15] Receiver checks only one stop bit.
// [RQ16] Control bits 5,4 select none, even or odd parity.
// [RQ17] Parity bit follows the data bits when enabled.
// [RQ18] Parity makes ones count odd or even, stops excluded.
// [RQ19] Control bit 3 selects input divide by four or three.
// [RQ20] Control bits 1,0 select five to eight data bits.
// [RQ21] Host writes a bit with select low, address, data and strobe.
// [RQ22] Transmit buffer loads only with all flags clear and break off.
// [RQ23] Each strobed write takes effect before the next strobe.
`timescale 1ns/100ps
`include "aslc_params.svh"
module aslc_core
  import aslc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Host bit write port
  input wire logic chip_sel_b,
  input wire logic [4:0] bit_addr_sel,
  input wire logic bit_write_data,
  input wire logic bit_write_strobe,
  // Transmitter status
  input wire logic tx_shift_empty,
  input wire logic tx_buffer_empty,
  // Channel pins
  input wire logic cts_pin_b,
  input wire logic dsr_pin_b,
  input wire logic serial_in_pin,
  input wire logic tx_serial_bit,
  output logic rts_b,
  output logic serial_out,
  // Internal channel view
  output logic cts_int_b,
  output logic dsr_int_b,
  output logic serial_in,
  // Register contents
  output logic [7:0] line_format_control,
  output logic [7:0] interval_reg,
  output logic [10:0] rx_rate_reg,
  output logic [10:0] tx_rate_reg,
  output logic [7:0] tx_buffer_reg,
  output logic tx_buffer_load,
  output logic dev_reset,
  // Decoded format
  output aslc_stop_t tx_stop_sel,
  output logic rx_one_stop,
  output logic parity_on,
  output logic parity_odd_sel,
  output logic [3:0] char_bits,
  output logic break_cmd,
  output logic loopback_test_bit,
  output logic [5:0] timer_speed,
  output logic tick,
  // Load flag view
  output logic ctrl_load_sel,
  output logic interval_load_sel,
  output logic rx_rate_load_sel,
  output logic tx_rate_load_sel
);
  logic rst_m_q;
  logic rst_sync_b;
  logic request_send_cmd_q;
  logic rts_act_q;
  logic break_q;
  logic test_q;
  logic [3:0] flags_q;
  logic [7:0] ctl_q;
  logic [7:0] int_q;
  logic [10:0] rxr_q;
  logic [10:0] txr_q;
  logic [7:0] txb_q;
  logic txb_ld_q;
  logic rst_pulse_q;
  logic wr_ok;
  logic data_wr;
  aslc_dst_t dst;
  aslc_wr_if wr ();

  // ==========================================================
  // Reset release
  // Two-stage release so the rest sees a clean deassert
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_sync_b <= rst_m_q;
    end
  end

  // ==========================================================
  // Write decode
  // [RQ21] select qualifies strobe
  assign wr.stb = bit_write_strobe && !chip_sel_b;
  assign wr.addr = bit_addr_sel;
  assign wr.data = bit_write_data;

  aslc_wr_dec u_dec (
    .wr (wr.dst),
    .flags (flags_q),
    .break_on (break_q),
    .dst (dst),
    .wr_ok (wr_ok)
  );

  assign data_wr = wr_ok && (wr.addr <= `ASLC_ADDR_DATA_TOP);

  // ==========================================================
  // Load flags, all on strobe so the next bit sees them
  // [RQ6] [RQ7] [RQ9] [RQ10] [RQ11] flag updates
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flags_q <= `ASLC_FLAGS_RST;
    end else if (wr_ok) begin
      // [RQ23] immediate update
      unique case (wr.addr)
        `ASLC_ADDR_RESET: flags_q <= `ASLC_FLAGS_RST;
        `ASLC_ADDR_LDCTL: flags_q[3] <= wr.data;
        `ASLC_ADDR_LDINT: flags_q[2] <= wr.data;
        `ASLC_ADDR_LDRX: flags_q[1] <= wr.data;
        `ASLC_ADDR_LDTX: flags_q[0] <= wr.data;
        `ASLC_ADDR_BYTE_TOP: begin
          if (dst == ASLC_DST_CTL) begin
            flags_q[3] <= 1'b0;
          end else if (dst == ASLC_DST_INT) begin
            flags_q[2] <= 1'b0;
          end
        end
        `ASLC_ADDR_DATA_TOP: begin
          // Only rx select self-clears; tx select is host-cleared
          if (dst == ASLC_DST_RATE) begin
            flags_q[1] <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Command bits
  // [RQ3] [RQ4] loopback and break commands
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      break_q <= 1'b0;
      test_q <= 1'b0;
      request_send_cmd_q <= 1'b0;
    end else if (wr_ok) begin
      if (wr.addr == `ASLC_ADDR_RESET) begin
        break_q <= 1'b0;
        request_send_cmd_q <= 1'b0;
      end
      if (wr.addr == `ASLC_ADDR_BREAK) begin
        break_q <= wr.data;
      end
      if (wr.addr == `ASLC_ADDR_TEST) begin
        test_q <= wr.data;
      end
      if (wr.addr == `ASLC_ADDR_RTS) begin
        request_send_cmd_q <= wr.data;
      end
    end
  end

  // [RQ1] [RQ2] rts active hold
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rts_act_q <= 1'b0;
    end else if (wr_ok && wr.addr == `ASLC_ADDR_RESET) begin
      rts_act_q <= 1'b0;
    end else if (wr_ok && wr.addr == `ASLC_ADDR_RTS && wr.data) begin
      rts_act_q <= 1'b1;
    end else if (!request_send_cmd_q && tx_shift_empty && tx_buffer_empty && !break_q) begin
      rts_act_q <= 1'b0;
    end
  end

  assign rts_b = !rts_act_q;

  // ==========================================================
  // Data registers
  // [RQ5] [RQ8] [RQ10] [RQ11] [RQ12] [RQ22] routed bit loads
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctl_q <= `ASLC_CTL_RST;
      int_q <= `ASLC_BYTE_RST;
      rxr_q <= `ASLC_RATE_RST;
      txr_q <= `ASLC_RATE_RST;
      txb_q <= `ASLC_BYTE_RST;
    end else if (data_wr) begin
      unique case (dst)
        ASLC_DST_CTL: begin
          if (wr.addr <= `ASLC_ADDR_BYTE_TOP) ctl_q[wr.addr[2:0]] <= wr.data;
        end
        ASLC_DST_INT: begin
          if (wr.addr <= `ASLC_ADDR_BYTE_TOP) int_q[wr.addr[2:0]] <= wr.data;
        end
        ASLC_DST_RATE: begin
          if (flags_q[1]) rxr_q[wr.addr[3:0]] <= wr.data;
          if (flags_q[0]) txr_q[wr.addr[3:0]] <= wr.data;
        end
        ASLC_DST_TXBUF: begin
          if (wr.addr <= `ASLC_ADDR_BYTE_TOP) txb_q[wr.addr[2:0]] <= wr.data;
        end
        ASLC_DST_NONE: ;
      endcase
    end
  end

  // Buffer-full pulse to the transmitter on its bit 7
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      txb_ld_q <= 1'b0;
      rst_pulse_q <= 1'b0;
    end else begin
      txb_ld_q <= data_wr && dst == ASLC_DST_TXBUF && wr.addr == `ASLC_ADDR_BYTE_TOP;
      rst_pulse_q <= wr_ok && wr.addr == `ASLC_ADDR_RESET;
    end
  end

  // ==========================================================
  // Loopback routing
  // [RQ3] [RQ4] pin or internal path
  assign cts_int_b = test_q ? rts_b : cts_pin_b;
  assign dsr_int_b = test_q ? 1'b0 : dsr_pin_b;
  assign serial_in = test_q ? tx_serial_bit : serial_in_pin;
  assign serial_out = test_q ? 1'b1 : tx_serial_bit;
  // Leaving the line idle in test keeps the far end quiet
  assign timer_speed = test_q ? `ASLC_LOOP_SPEEDUP : 6'h01;

  // ==========================================================
  // Format decode
  // [RQ14] stop bits
  assign tx_stop_sel = ctl_q[`ASLC_CTL_STOP_HI] ? ASLC_STOP_ONE :
                       (ctl_q[`ASLC_CTL_STOP_LO] ? ASLC_STOP_TWO : ASLC_STOP_ONE_HALF);
  // [RQ15] receiver single stop
  assign rx_one_stop = 1'b1;
  // [RQ16] [RQ17] [RQ18] parity enable and sense
  assign parity_on = ctl_q[`ASLC_CTL_PAR_ON];
  assign parity_odd_sel = ctl_q[`ASLC_CTL_PAR_ON] && ctl_q[`ASLC_CTL_PAR_ODD];
  // [RQ20] character length
  assign char_bits = 4'h5 + {2'h0, ctl_q[`ASLC_CTL_LEN_HI], ctl_q[`ASLC_CTL_LEN_LO]};

  // [RQ19] internal time base
  aslc_clk_div u_div (
    .clk (clk),
    .rst_sync_b (rst_sync_b),
    .div4_sel (ctl_q[`ASLC_CTL_DIV4]),
    .tick (tick)
  );

  // Register views
  assign line_format_control = ctl_q;
  assign interval_reg = int_q;
  assign rx_rate_reg = rxr_q;
  assign tx_rate_reg = txr_q;
  assign tx_buffer_reg = txb_q;
  assign tx_buffer_load = txb_ld_q;
  assign dev_reset = rst_pulse_q;
  assign break_cmd = break_q;
  assign loopback_test_bit = test_q;
  assign ctrl_load_sel = flags_q[3];
  assign interval_load_sel = flags_q[2];
  assign rx_rate_load_sel = flags_q[1];
  assign tx_rate_load_sel = flags_q[0];

  // ==========================================================
  // Checks
  property p_rts_on;
    @(posedge clk) disable iff (!rst_sync_b)
      (wr_ok && wr.addr == `ASLC_ADDR_RTS && wr.data) |=> !rts_b;
  endproperty
  a_rts_on: assert property (p_rts_on) else $error("rts not active after set"); // [RQ1]

  property p_rts_hold;
    @(posedge clk) disable iff (!rst_sync_b)
      (!rts_b && !(tx_shift_empty && tx_buffer_empty && !break_q) &&
       !(wr_ok && wr.addr == `ASLC_ADDR_RESET)) |=> !rts_b;
  endproperty
  a_rts_hold: assert property (p_rts_hold) else $error("rts dropped early"); // [RQ2]

  property p_loop;
    @(posedge clk) disable iff (!rst_sync_b)
      test_q |-> (cts_int_b == rts_b) && !dsr_int_b && serial_in == tx_serial_bit &&
        timer_speed == `ASLC_LOOP_SPEEDUP;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback routing wrong"); // [RQ3]

  property p_unloop;
    @(posedge clk) disable iff (!rst_sync_b)
      !test_q |-> cts_int_b == cts_pin_b && serial_in == serial_in_pin && timer_speed == 6'h01 &&
        dsr_int_b == dsr_pin_b;
  endproperty
  a_unloop: assert property (p_unloop) else $error("normal routing wrong"); // [RQ4]

  property p_reset_flags;
    @(posedge clk) disable iff (!rst_sync_b)
      (wr_ok && wr.addr == `ASLC_ADDR_RESET) |=> flags_q == 4'hF;
  endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("reset write left flags"); // [RQ7]

  property p_ctl_clear;
    @(posedge clk) disable iff (!rst_sync_b)
      (wr_ok && flags_q[3] && wr.addr == 5'h07) |=> !flags_q[3] && ctl_q[7] == $past(wr.data);
  endproperty
  a_ctl_clear: assert property (p_ctl_clear) else $error("control select not cleared"); // [RQ9]

  property p_both_rates;
    @(posedge clk) disable iff (!rst_sync_b)
      (data_wr && flags_q[1:0] == 2'b11 && flags_q[3:2] == 2'b00) |=>
        rxr_q[$past(wr.addr[3:0])] == $past(wr.data) &&
        txr_q[$past(wr.addr[3:0])] == $past(wr.data);
  endproperty
  a_both_rates: assert property (p_both_rates) else $error("rates diverged"); // [RQ12]

  property p_txb_block;
    @(posedge clk) disable iff (!rst_sync_b)
      (data_wr && (flags_q != 4'h0 || break_q)) |=> $stable(txb_q);
  endproperty
  a_txb_block: assert property (p_txb_block) else $error("buffer loaded while blocked"); // [RQ22]
endmodule : aslc_core

// ===== core/aslc_wr_dec.sv
/*
  Load destination decode from the four flags and break command.
  Assumes flags ordered {control, interval, rx rate, tx rate}.
*/
`timescale 1ns/100ps
module aslc_wr_dec
  import aslc_pkg::*;
(
  // Write carrier
  aslc_wr_if.dst wr,
  // State
  input wire logic [3:0] flags,
  input wire logic break_on,
  // Decode
  output aslc_dst_t dst,
  output logic wr_ok
);
  // Fixed priority pick, reused for every data bit
  function automatic aslc_dst_t pick(input logic [3:0] f, input logic brk);
    if (f[3]) return ASLC_DST_CTL;
    if (f[2]) return ASLC_DST_INT;
    if (f[1] || f[0]) return ASLC_DST_RATE;
    if (brk) return ASLC_DST_NONE;
    return ASLC_DST_TXBUF;
  endfunction : pick

  // [RQ5] [RQ22] priority select
  assign dst = pick(flags, break_on);
  assign wr_ok = wr.stb;
endmodule : aslc_wr_dec

// ===== test/aslc_host_model.sv
/*
  Host model: writes single addressed bits into the load control block.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
module aslc_host_model (
  // Clock
  input wire logic clk,
  // Bit write port
  output logic chip_sel_b,
  output logic [4:0] bit_addr_sel,
  output logic bit_write_data,
  output logic bit_write_strobe
);
  // ==========================================================
  // Idle port
  initial begin
    chip_sel_b = 1'b1;
    bit_addr_sel = 5'h00;
    bit_write_data = 1'b0;
    bit_write_strobe = 1'b0;
  end

  // ==========================================================
  // Strobed bit sequences
  // select, address, data, strobe
  // Strobe stays high across a sequence so bits land back to back; released
  // lines show the inverse so a stale value never passes for a write
  task automatic write_seq(input logic [4:0] base, input logic [11:0] val, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      chip_sel_b = 1'b0;
      bit_addr_sel = base + i[4:0];
      bit_write_data = val[i];
      bit_write_strobe = 1'b1;
      @(posedge clk);
      #1;
    end
    chip_sel_b = 1'b1;
    bit_write_strobe = 1'b0;
    bit_addr_sel = ~bit_addr_sel;
    bit_write_data = ~bit_write_data;
    // One idle edge so the next call never raises the strobe just lowered
    @(posedge clk);
    #1;
  endtask : write_seq

  // One command or flag bit
  task automatic wr_bit(input logic [4:0] a, input logic d);
    write_seq(a, {11'h000, d}, 1);
  endtask : wr_bit

  // Eight bits from the given address up
  task automatic wr_byte(input logic [4:0] a, input logic [7:0] d);
    write_seq(a, {4'h0, d}, 8);
  endtask : wr_byte

  // Eleven rate bits
  task automatic wr_rate(input logic [10:0] d);
    write_seq(5'h00, {1'b0, d}, 11);
  endtask : wr_rate

  task automatic wr_rate12(input logic [11:0] d);
    write_seq(5'h00, d, 12);
  endtask : wr_rate12
endmodule : aslc_host_model

// ===== test/aslc_core_bench.sv
/*
  Self-checking bench for the register load control block.
  Assumes the host model drives the bit port; clock runs at 200 MHz.
*/
`timescale 1ns/100ps
module aslc_core_bench
  import aslc_pkg::*;
;
  // ==========================================================
  // Signals
  logic clk, rst_b, tx_shift_empty, tx_buffer_empty, cts_pin_b, dsr_pin_b;
  logic serial_in_pin, tx_serial_bit, chip_sel_b, bit_write_data, bit_write_strobe;
  logic [4:0] bit_addr_sel;
  logic rts_b, serial_out, cts_int_b, dsr_int_b, serial_in, tx_buffer_load, dev_reset;
  logic [7:0] line_format_control, interval_reg, tx_buffer_reg;
  logic [10:0] rx_rate_reg, tx_rate_reg;
  aslc_stop_t tx_stop_sel;
  logic rx_one_stop, parity_on, parity_odd_sel, break_cmd, loopback_test_bit, tick;
  logic [3:0] char_bits, flags;
  logic [5:0] timer_speed;
  logic ctrl_load_sel, interval_load_sel, rx_rate_load_sel, tx_rate_load_sel;
  int mismatches, n_compared, cycles, n_loads, n_resets, gap, i;
  logic [7:0] c;
  logic [7:0] ctl_tab [4] = '{8'h00, 8'h5A, 8'hB1, 8'hE3};

  assign flags = {ctrl_load_sel, interval_load_sel, rx_rate_load_sel, tx_rate_load_sel};

  // ==========================================================
  // Design and host
  aslc_core dut (.clk(clk), .rst_b(rst_b), .chip_sel_b(chip_sel_b),
    .bit_addr_sel(bit_addr_sel), .bit_write_data(bit_write_data),
    .bit_write_strobe(bit_write_strobe), .tx_shift_empty(tx_shift_empty),
    .tx_buffer_empty(tx_buffer_empty), .cts_pin_b(cts_pin_b), .dsr_pin_b(dsr_pin_b),
    .serial_in_pin(serial_in_pin), .tx_serial_bit(tx_serial_bit), .rts_b(rts_b),
    .serial_out(serial_out), .cts_int_b(cts_int_b), .dsr_int_b(dsr_int_b),
    .serial_in(serial_in), .line_format_control(line_format_control),
    .interval_reg(interval_reg), .rx_rate_reg(rx_rate_reg), .tx_rate_reg(tx_rate_reg),
    .tx_buffer_reg(tx_buffer_reg), .tx_buffer_load(tx_buffer_load), .dev_reset(dev_reset),
    .tx_stop_sel(tx_stop_sel), .rx_one_stop(rx_one_stop), .parity_on(parity_on),
    .parity_odd_sel(parity_odd_sel), .char_bits(char_bits), .break_cmd(break_cmd),
    .loopback_test_bit(loopback_test_bit), .timer_speed(timer_speed), .tick(tick),
    .ctrl_load_sel(ctrl_load_sel), .interval_load_sel(interval_load_sel),
    .rx_rate_load_sel(rx_rate_load_sel), .tx_rate_load_sel(tx_rate_load_sel));

  aslc_host_model host (.clk(clk), .chip_sel_b(chip_sel_b), .bit_addr_sel(bit_addr_sel),
    .bit_write_data(bit_write_data), .bit_write_strobe(bit_write_strobe));

  // ==========================================================
  // Clock, pulse counters and hang guard
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  // Pulses are counted at the edge so a one-cycle pulse is never missed
  always @(posedge clk) begin
    cycles++;
    if (tx_buffer_load === 1'b1)
      n_loads++;
    if (dev_reset === 1'b1)
      n_resets++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic check_val(input logic [10:0] got, input logic [10:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // Clocks between two time base enables, bounded
  task automatic tick_gap(output int g);
    int k;
    for (k = 0; k < 10 && tick !== 1'b1; k++)
      step(1);
    g = 0;
    do begin
      step(1);
      g++;
    end while (tick !== 1'b1 && g < 10);
  endtask : tick_gap

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // Test sequence
  initial begin
    rst_b = 1'b0;
    tx_shift_empty = 1'b0;
    tx_buffer_empty = 1'b0;
    cts_pin_b = 1'b1;
    dsr_pin_b = 1'b1;
    serial_in_pin = 1'b1;
    tx_serial_bit = 1'b0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    n_loads = 0;
    n_resets = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    step(4);
    check_val(flags, 11'h00F);
    check_val(rts_b, 11'h001);
    // Every stop, parity, divide and length code
    for (i = 0; i < 4; i++) begin
      c = ctl_tab[i];
      host.wr_bit(5'h0E, 1'b1);
      host.wr_byte(5'h00, c);
      check_val(line_format_control, c);
      check_val(ctrl_load_sel, 11'h000);
      check_val(tx_stop_sel, c[7] ? ASLC_STOP_ONE : (c[6] ? ASLC_STOP_TWO
        : ASLC_STOP_ONE_HALF));
      check_val(rx_one_stop, 11'h001);
      check_val({parity_on, parity_odd_sel}, {c[5], c[5] & c[4]});
      check_val(char_bits, 11'd5 + c[1:0]);
      tick_gap(gap);
      check_val(gap[10:0], c[3] ? 11'd4 : 11'd3);
    end
    host.wr_byte(5'h00, 8'hA5);
    check_val(interval_reg, 11'h0A5);
    check_val(line_format_control, 11'h0E3);
    check_val(flags, 11'h003);
    host.wr_rate(11'h5A3);
    check_val(rx_rate_reg, 11'h5A3);
    check_val(tx_rate_reg, 11'h5A3);
    check_val(flags, 11'h001);
    host.wr_rate12(12'h2C4);
    check_val(tx_rate_reg, 11'h2C4);
    check_val(rx_rate_reg, 11'h5A3);
    check_val(flags, 11'h000);
    host.wr_byte(5'h00, 8'hC6);
    step(1);
    check_val(tx_buffer_reg, 11'h0C6);
    check_val(n_loads[10:0], 11'h001);
    host.wr_bit(5'h11, 1'b1);
    check_val(break_cmd, 11'h001);
    host.wr_byte(5'h00, 8'h3C);
    step(1);
    check_val(tx_buffer_reg, 11'h0C6);
    check_val(n_loads[10:0], 11'h001);
    // Request-send release waits for empty transmitter and break off
    host.wr_bit(5'h10, 1'b1);
    check_val(rts_b, 11'h000);
    host.wr_bit(5'h10, 1'b0);
    step(3);
    check_val(rts_b, 11'h000);
    tx_shift_empty = 1'b1;
    tx_buffer_empty = 1'b1;
    step(3);
    check_val(rts_b, 11'h000);
    host.wr_bit(5'h11, 1'b0);
    step(2);
    check_val(rts_b, 11'h001);
    // Loopback routing and timer rate
    host.wr_bit(5'h10, 1'b1);
    host.wr_bit(5'h0F, 1'b1);
    check_val(loopback_test_bit, 11'h001);
    check_val(timer_speed, 11'd32);
    check_val({cts_int_b, dsr_int_b, serial_in, serial_out}, 11'h001);
    host.wr_bit(5'h0F, 1'b0);
    check_val(timer_speed, 11'd1);
    check_val({cts_int_b, dsr_int_b, serial_in, serial_out}, 11'h00E);
    // Unused address leaves the flags alone
    host.wr_bit(5'h14, 1'b1);
    check_val(flags, 11'h000);
    host.wr_bit(5'h1F, 1'b0);
    step(12);
    check_val(flags, 11'h00F);
    check_val(n_resets[10:0], 11'h001);
    host.wr_bit(5'h0E, 1'b0);
    host.wr_byte(5'h00, 8'h3D);
    check_val(interval_reg, 11'h03D);
    check_val(line_format_control, 11'h0E3);
    for (i = 0; i < 4; i++) begin
      host.wr_bit(5'h0B + i[4:0], 1'b0);
      check_val(flags[i], 11'h000);
      host.wr_bit(5'h0B + i[4:0], 1'b1);
      check_val(flags[i], 11'h001);
    end
    report_and_stop();
  end
endmodule : aslc_core_bench
